/* verilog/rtsc_capture.sv */
// timestamp capture unit: pin event detection, flags, capture registers
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - ground event with enable asserts interrupt low
// - interrupt held until both flags cleared
// - ground flag re-set only on fresh ground
// - control bit 7 picks keep-last or keep-first
// - control bits 4..0 hold BCD sixteenths
// - unimplemented bits read as zero
// - capture fields untouched by reset
// - seconds BCD, tens 6..4, units 3..0
// - minutes BCD, tens 6..4, units 3..0
// - 12-hour: PM bit 5, tens bit 4
// - 24-hour: tens bits 5..4, units 3..0
// - hour format follows hour-format control bit
// - day BCD, tens bits 5..4
// - month BCD, tens bit 4
// - year BCD across all eight bits
// - intermediate-level edge captures, sets level flag
// - ground captures, sets both flags
// - enabled after power-on; bit 6 disables
// - battery switch-over capture, flag blocks further
module rtsc_capture (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic [1:0] capture_input_n_lvl_in,
  input wire logic capture_irq_enable_in,
  input wire logic flag_level_clr_in,
  input wire logic flag_ground_clr_in,
  input wire logic hour_mode_12_in,
  input wire logic battery_switch_capture_en_in,
  input wire logic battery_switch_event_in,
  input wire logic battery_flag_clr_in,
  input wire logic [4:0] cal_sub16_in,
  input wire logic [6:0] cal_sec_in,
  input wire logic [6:0] cal_min_in,
  input wire logic [5:0] cal_hour24_in,
  input wire logic [5:0] cal_day_in,
  input wire logic [4:0] cal_mon_in,
  input wire logic [7:0] cal_year_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic capture_flag_level_out,
  output logic capture_flag_ground_out,
  output logic battery_switched_flag_out,
  output logic capture_irq_n_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  // assert at once, release two edges later so state leaves reset cleanly
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hour format conversion
  function automatic logic [5:0] hour_fmt(input logic [5:0] h24,
                                          input logic mode12);
    logic [4:0] bin;
    logic [4:0] h12;
    logic pm;
    logic tens;
    logic [4:0] units;
    bin = 5'(h24[5:4]) * rtsc_pkg::BCD_TEN + 5'(h24[3:0]);
    pm = (bin >= rtsc_pkg::HOURS_HALF_DAY);
    h12 = pm ? 5'(bin - rtsc_pkg::HOURS_HALF_DAY) : bin;
    if (h12 == 5'h00) begin
      h12 = rtsc_pkg::HOURS_HALF_DAY;
    end
    tens = (h12 >= rtsc_pkg::BCD_TEN);
    units = tens ? 5'(h12 - rtsc_pkg::BCD_TEN) : h12;
    if (mode12) begin
      hour_fmt = {pm, tens, units[3:0]};
    end else begin
      hour_fmt = h24;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  rtsc_pkg::rtsc_ctl_t ctl_q;
  rtsc_pkg::rtsc_ctl_t ctl_d;
  rtsc_pkg::rtsc_cap_t cap_q;
  rtsc_pkg::rtsc_cap_t cap_d;

  logic evt_level;
  logic evt_ground;
  logic pin_ok;
  logic flags_any;
  logic pin_go;
  logic bat_go;
  logic cap_go;
  logic ctl_wr;

  // event decode: entering the middle from either rail, or reaching ground
  always_comb begin
    evt_level = (capture_input_n_lvl_in == rtsc_pkg::PIN_MID) &&
      (ctl_q.pin_prev != rtsc_pkg::PIN_MID);
    evt_ground = (capture_input_n_lvl_in == rtsc_pkg::PIN_GND) &&
      (ctl_q.pin_prev != rtsc_pkg::PIN_GND);
    pin_ok = !ctl_q.disable_cap && !ctl_q.bat_flag;
    flags_any = ctl_q.flag_level || ctl_q.flag_ground;
    pin_go = pin_ok && (evt_level || evt_ground);
    bat_go = battery_switch_event_in && battery_switch_capture_en_in &&
      !ctl_q.bat_flag;
    // keep-first mode freezes the first snapshot against pin events while a flag is up; a switch-over capture still loads
    cap_go = (pin_go && !(ctl_q.keep_first && flags_any)) || bat_go;
    ctl_wr = reg_wr_in && (reg_addr_in == rtsc_pkg::ADDR_CAP_CONTROL);
  end

  // control, flags, interrupt and read data
  always_comb begin
    ctl_d = ctl_q;
    ctl_d.pin_prev = capture_input_n_lvl_in;
    if (ctl_wr) begin
      ctl_d.keep_first = reg_wdata_in[rtsc_pkg::CTL_KEEP_FIRST_BIT];
      ctl_d.disable_cap = reg_wdata_in[rtsc_pkg::CTL_DISABLE_BIT];
    end
    // clears first, so a same-cycle pin event wins over them; a switch-over event is still blocked by its set flag
    if (flag_level_clr_in) begin
      ctl_d.flag_level = 1'b0;
    end
    if (flag_ground_clr_in) begin
      ctl_d.flag_ground = 1'b0;
    end
    if (battery_flag_clr_in) begin
      ctl_d.bat_flag = 1'b0;
    end
    if (pin_go) begin
      ctl_d.flag_level = 1'b1;
    end
    if (pin_go && evt_ground) begin
      ctl_d.flag_ground = 1'b1;
    end
    if (bat_go) begin
      ctl_d.bat_flag = 1'b1;
    end
    // level interrupt, no pulse mode for this source
    ctl_d.irq_n = !(capture_irq_enable_in &&
      (ctl_d.flag_level || ctl_d.flag_ground));
    ctl_d.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        rtsc_pkg::ADDR_CAP_CONTROL:
          ctl_d.rdata = {ctl_q.keep_first, ctl_q.disable_cap, 1'b0,
            cap_q.sub16};
        rtsc_pkg::ADDR_CAP_SECONDS: ctl_d.rdata = {1'b0, cap_q.sec};
        rtsc_pkg::ADDR_CAP_MINUTES: ctl_d.rdata = {1'b0, cap_q.min};
        rtsc_pkg::ADDR_CAP_HOURS: ctl_d.rdata = {2'b00, cap_q.hour};
        rtsc_pkg::ADDR_CAP_DAY: ctl_d.rdata = {2'b00, cap_q.day};
        rtsc_pkg::ADDR_CAP_MONTH: ctl_d.rdata = {3'b000, cap_q.mon};
        rtsc_pkg::ADDR_CAP_YEAR: ctl_d.rdata = cap_q.year;
        default: ctl_d.rdata = 8'h00; // other offsets belong elsewhere
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctl_q.keep_first <= rtsc_pkg::RST_KEEP_FIRST;
      ctl_q.disable_cap <= rtsc_pkg::RST_DISABLE;
      ctl_q.flag_level <= 1'b0;
      ctl_q.flag_ground <= 1'b0;
      ctl_q.bat_flag <= 1'b0;
      ctl_q.pin_prev <= rtsc_pkg::PIN_HIGH;
      ctl_q.irq_n <= 1'b1;
      ctl_q.rdata <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture fields: one edge loads every field from the same calendar
  // sample; no reset so a warm reset keeps the evidence
  always_comb begin
    cap_d = cap_q;
    if (cap_go) begin
      cap_d.sub16 = cal_sub16_in;
      cap_d.sec = cal_sec_in;
      cap_d.min = cal_min_in;
      cap_d.hour = hour_fmt(cal_hour24_in, hour_mode_12_in);
      cap_d.day = cal_day_in;
      cap_d.mon = cal_mon_in;
      cap_d.year = cal_year_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    cap_q <= cap_d;
  end

  assign reg_rdata_out = ctl_q.rdata;
  assign capture_flag_level_out = ctl_q.flag_level;
  assign capture_flag_ground_out = ctl_q.flag_ground;
  assign battery_switched_flag_out = ctl_q.bat_flag;
  assign capture_irq_n_out = ctl_q.irq_n;

  ////////////////////////////////////////////////////////////////////////
  // checks
  irq_on_flag_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    ($past(capture_irq_enable_in) &&
     (capture_flag_level_out || capture_flag_ground_out))
    |-> !capture_irq_n_out)
    else $error("interrupt not asserted with flag and enable");

  irq_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (!capture_irq_n_out && capture_irq_enable_in &&
     (capture_flag_level_out || capture_flag_ground_out))
    ##1 (capture_flag_level_out || capture_flag_ground_out)
    |-> !capture_irq_n_out)
    else $error("interrupt released while a flag stands");

  ground_fresh_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    $rose(capture_flag_ground_out) |->
      $past(capture_input_n_lvl_in) == rtsc_pkg::PIN_GND &&
      $past(ctl_q.pin_prev) != rtsc_pkg::PIN_GND)
    else $error("ground flag set without fresh ground edge");

  keep_first_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (ctl_q.keep_first && flags_any && !bat_go) |=> $stable(cap_q))
    else $error("keep-first mode overwrote capture");

  ground_both_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (evt_ground && pin_ok) |=>
      capture_flag_level_out && capture_flag_ground_out)
    else $error("ground event did not set both flags");

  disabled_quiet_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (ctl_q.disable_cap && !flag_level_clr_in && !bat_go) |=>
      !$rose(capture_flag_level_out) && $stable(cap_q))
    else $error("disabled unit reacted to pin");

  battery_block_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (ctl_q.bat_flag && !flag_level_clr_in) |=>
      !$rose(capture_flag_level_out) && $stable(cap_q))
    else $error("event registered while switch-over flag set");

  read_zero_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (reg_rd_in && reg_addr_in == rtsc_pkg::ADDR_CAP_CONTROL) |=>
      reg_rdata_out[5] == 1'b0)
    else $error("unimplemented control bit read as one");

  ctl_write_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    ctl_wr |=> ctl_q.disable_cap == $past(reg_wdata_in[6]) &&
      ctl_q.keep_first == $past(reg_wdata_in[7]))
    else $error("control write not taken");

  level_set_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (evt_level && pin_ok) |=> capture_flag_level_out)
    else $error("level event did not set level flag");

  level_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (capture_flag_level_out && !flag_level_clr_in) |=>
      capture_flag_level_out)
    else $error("level flag dropped without a clear");

  ground_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (capture_flag_ground_out && !flag_ground_clr_in) |=>
      capture_flag_ground_out)
    else $error("ground flag dropped without a clear");

  irq_clear_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    !(capture_flag_level_out || capture_flag_ground_out) |->
      capture_irq_n_out)
    else $error("interrupt low with both flags clear");

  bat_set_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    bat_go |=> battery_switched_flag_out)
    else $error("switch-over capture did not set its flag");

  capture_load_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    cap_go |=> cap_q.sub16 == $past(cal_sub16_in) &&
      cap_q.sec == $past(cal_sec_in) && cap_q.min == $past(cal_min_in) &&
      cap_q.day == $past(cal_day_in) && cap_q.mon == $past(cal_mon_in) &&
      cap_q.year == $past(cal_year_in))
    else $error("capture fields not loaded from one sample");

  hour24_copy_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (cap_go && !hour_mode_12_in) |=>
      cap_q.hour == $past(cal_hour24_in))
    else $error("24-hour capture altered the hour");

  hour12_fmt_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (cap_go && hour_mode_12_in) |=>
      cap_q.hour[4:0] != 5'h00 && cap_q.hour[4:0] <= 5'h12 &&
      cap_q.hour[3:0] <= 4'h9 &&
      cap_q.hour[5] == ($past(cal_hour24_in) >= 6'h12))
    else $error("12-hour capture out of range or wrong half");

  sec_top_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (reg_rd_in && reg_addr_in == rtsc_pkg::ADDR_CAP_SECONDS) |=>
      reg_rdata_out[7] == 1'h0)
    else $error("unused seconds bit read as one");

  hour_top_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (reg_rd_in && reg_addr_in == rtsc_pkg::ADDR_CAP_HOURS) |=>
      reg_rdata_out[7:6] == 2'h0)
    else $error("unused hour bits read as one");

  day_top_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (reg_rd_in && reg_addr_in == rtsc_pkg::ADDR_CAP_DAY) |=>
      reg_rdata_out[7:6] == 2'h0)
    else $error("unused day bits read as one");

  month_top_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    (reg_rd_in && reg_addr_in == rtsc_pkg::ADDR_CAP_MONTH) |=>
      reg_rdata_out[7:5] == 3'h0)
    else $error("unused month bits read as one");

  rdata_idle_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_q)
    !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not back to zero");

endmodule // rtsc_capture

`default_nettype wire

/* verilog/rtsc_pkg.sv */
// constants shared by the timestamp capture unit
package rtsc_pkg;
  // register offsets on the device register port
  localparam logic [7:0] ADDR_CAP_CONTROL = 8'h12;
  localparam logic [7:0] ADDR_CAP_SECONDS = 8'h13;
  localparam logic [7:0] ADDR_CAP_MINUTES = 8'h14;
  localparam logic [7:0] ADDR_CAP_HOURS = 8'h15;
  localparam logic [7:0] ADDR_CAP_DAY = 8'h16;
  localparam logic [7:0] ADDR_CAP_MONTH = 8'h17;
  localparam logic [7:0] ADDR_CAP_YEAR = 8'h18;
  // capture_control field positions
  localparam int CTL_KEEP_FIRST_BIT = 7;
  localparam int CTL_DISABLE_BIT = 6;
  // control reset values: last-event mode, capture enabled
  localparam logic RST_KEEP_FIRST = 1'h0;
  localparam logic RST_DISABLE = 1'h0;
  // coded level of the multilevel capture pin
  localparam logic [1:0] PIN_HIGH = 2'h3;
  localparam logic [1:0] PIN_MID = 2'h1;
  localparam logic [1:0] PIN_GND = 2'h0;
  // hour arithmetic
  localparam logic [4:0] HOURS_HALF_DAY = 5'h0c;
  localparam logic [4:0] BCD_TEN = 5'h0a;

  // reset-held control and status state
  typedef struct packed {
    logic keep_first;
    logic disable_cap;
    logic flag_level;
    logic flag_ground;
    logic bat_flag;
    logic [1:0] pin_prev;
    logic irq_n;
    logic [7:0] rdata;
  } rtsc_ctl_t;

  // capture fields, kept across resets
  typedef struct packed {
    logic [4:0] sub16;
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [5:0] day;
    logic [4:0] mon;
    logic [7:0] year;
  } rtsc_cap_t;
endpackage

/* bench/rtsc_pin_model.sv */
// tamper switch model driving the coded level of the capture pin
`timescale 1ns/1ps
`default_nettype none
module rtsc_pin_model (
  input wire logic clk_in,
  input wire logic [1:0] lvl_req_in,
  output var logic [1:0] lvl_out
);
  // idle pin sits high through its pull-up until the switch moves
  initial lvl_out = rtsc_pkg::PIN_HIGH;
  // contacts settle on the falling edge, clear of the sampling edge
  always @(negedge clk_in) begin
    lvl_out <= lvl_req_in;
  end
endmodule // rtsc_pin_model
`default_nettype wire

/* bench/rtsc_capture_tb.sv */
// self-checking testbench for the timestamp capture unit
`timescale 1ns/1ps
`default_nettype none
module rtsc_capture_tb;
  logic clk_sys_in = 1'h0;
  logic nrst_in = 1'h0;
  logic [1:0] lvl_req = rtsc_pkg::PIN_HIGH;
  logic [1:0] lvl;
  logic irq_en = 1'h0, clr_l = 1'h0, clr_g = 1'h0, clr_b = 1'h0;
  logic mode12 = 1'h0, bat_en = 1'h0, bat_ev = 1'h0;
  logic [4:0] sub, mon;
  logic [6:0] sec, min;
  logic [5:0] hr, day;
  logic [7:0] yr, addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'h0, rd = 1'h0, fl, fg, bf, irq_n;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [55:0] CAP_A = 56'h95_59_37_31_31_12_99;
  localparam logic [55:0] CAP_B = 56'h00_00_00_12_01_01_00;

  always #5 clk_sys_in = ~clk_sys_in;

  rtsc_pin_model rtsc_pin_model_i (.clk_in(clk_sys_in),
    .lvl_req_in(lvl_req), .lvl_out(lvl));
  rtsc_capture rtsc_capture_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .capture_input_n_lvl_in(lvl), .capture_irq_enable_in(irq_en),
    .flag_level_clr_in(clr_l), .flag_ground_clr_in(clr_g),
    .hour_mode_12_in(mode12), .battery_switch_capture_en_in(bat_en),
    .battery_switch_event_in(bat_ev), .battery_flag_clr_in(clr_b),
    .cal_sub16_in(sub), .cal_sec_in(sec), .cal_min_in(min),
    .cal_hour24_in(hr), .cal_day_in(day), .cal_mon_in(mon),
    .cal_year_in(yr), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .capture_flag_level_out(fl), .capture_flag_ground_out(fg),
    .battery_switched_flag_out(bf), .capture_irq_n_out(irq_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // read data is registered, so it is sampled one cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_in);
    rd = 1'h1;
    addr = a;
    @(negedge clk_sys_in);
    rd = 1'h0;
    check($sformatf("reg %h", a), rdata, exp);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    wr = 1'h1;
    addr = a;
    wdata = d;
    @(negedge clk_sys_in);
    wr = 1'h0;
  endtask
  // walks the control and six capture registers in address order
  task automatic cap_chk(input logic [55:0] e);
    for (int i = 0; i < 7; i++) begin
      rd_chk(rtsc_pkg::ADDR_CAP_CONTROL + 8'(i), e[55-8*i -: 8]);
    end
  endtask
  // order: irq_n, level flag, ground flag, switch-over flag
  task automatic flags(input logic [3:0] e);
    check("flags", {4'h0, irq_n, fl, fg, bf}, {4'h0, e});
  endtask
  // calendar bytes in register order: sub16, sec, min, hour, day, mon, year
  task automatic cal(input logic [55:0] v);
    sub = v[52:48];
    sec = v[46:40];
    min = v[38:32];
    hr = v[29:24];
    day = v[21:16];
    mon = v[12:8];
    yr = v[7:0];
  endtask
  task automatic pin(input logic [1:0] l);
    // non-blocking, so the model's falling-edge sample never races us
    lvl_req <= l;
    repeat (3) @(negedge clk_sys_in);
  endtask
  // one-cycle pulses: level clear, ground clear, switch clear, switch event
  task automatic pulse(input logic [3:0] m);
    @(negedge clk_sys_in);
    {clr_l, clr_g, clr_b, bat_ev} = m;
    @(negedge clk_sys_in);
    {clr_l, clr_g, clr_b, bat_ev} = 4'h0;
  endtask
  task automatic do_reset();
    nrst_in = 1'h0;
    repeat (3) @(negedge clk_sys_in);
    nrst_in = 1'h1;
    repeat (4) @(negedge clk_sys_in);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang is cut short well past the 190 or so cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    cal(56'h15_59_37_23_31_12_99);
    do_reset();
    pin(rtsc_pkg::PIN_MID);
    flags(4'b1100);
    cap_chk(56'h15_59_37_23_31_12_99);
    pulse(4'b1000);
    irq_en = 1'h1;
    mode12 = 1'h1;
    cal(56'h00_00_00_00_01_01_00);
    pin(rtsc_pkg::PIN_HIGH);
    pin(rtsc_pkg::PIN_GND);
    flags(4'b0110);
    cap_chk(CAP_B);
    cal(56'h09_01_02_13_10_10_20);
    pin(rtsc_pkg::PIN_MID);
    cap_chk(56'h09_01_02_21_10_10_20);
    pin(rtsc_pkg::PIN_GND);
    pulse(4'b1000);
    flags(4'b0010);
    pulse(4'b0100);
    flags(4'b1000);
    pin(rtsc_pkg::PIN_GND);
    flags(4'b1000);
    $display("test ground done");
    wr_reg(rtsc_pkg::ADDR_CAP_CONTROL, 8'h80);
    cal(56'h15_59_37_23_31_12_99);
    pin(rtsc_pkg::PIN_MID);
    cal(56'h00_00_00_00_01_01_00);
    pin(rtsc_pkg::PIN_GND);
    flags(4'b0110);
    cap_chk(CAP_A);
    wr_reg(rtsc_pkg::ADDR_CAP_CONTROL, 8'h40);
    pulse(4'b1100);
    pin(rtsc_pkg::PIN_HIGH);
    pin(rtsc_pkg::PIN_MID);
    flags(4'b1000);
    cap_chk({8'h55, CAP_A[47:0]});
    pin(rtsc_pkg::PIN_HIGH);
    do_reset();
    cap_chk({8'h15, CAP_A[47:0]});
    flags(4'b1000);
    $display("test modes done");
    irq_en = 1'h0;
    bat_en = 1'h1;
    pulse(4'b0001);
    flags(4'b1001);
    cap_chk(CAP_B);
    cal(56'h09_01_02_13_10_10_20);
    pin(rtsc_pkg::PIN_GND);
    pulse(4'b0001);
    flags(4'b1001);
    cap_chk(CAP_B);
    pulse(4'b0010);
    flags(4'b1000);
    wr_reg(rtsc_pkg::ADDR_CAP_SECONDS, 8'hff);
    rd_chk(rtsc_pkg::ADDR_CAP_SECONDS, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("test battery done");
    print_verdict();
  end
endmodule // rtsc_capture_tb
`default_nettype wire
